// file: tb_top.sv
// Self-checking bench for the test control register bank.
// Assumes tcl_cfg.svh and tcl_pkg are compiled ahead of the bank.
`include "tcl_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic halt_detect_raw = 1'b0;
  logic pump_mode_hw = 1'b0;
  logic test_mode_active = 1'b0;
  logic [7:0] reg_rdata_r;
  tcl_pkg::tcl_analog_t analog_r;
  logic pump_mode_eff_r, halt_detect_out_r, bandgap_on_r, unlocked_r;
  tcl_pkg::tcl_test_mode_t test_mode_r;
  tcl_pkg::tcl_test_dec_t test_dec_r;
  int bad_count = 0;
  int num_checks = 0;

  // Key values differ from the bank defaults so the parameters are used.
  tcl_bank #(.KEY_ONE(8'hA5), .KEY_TWO(8'h3C)) u_tcl_bank (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .halt_detect_raw(halt_detect_raw),
    .pump_mode_hw(pump_mode_hw), .test_mode_active(test_mode_active),
    .analog_r(analog_r), .pump_mode_eff_r(pump_mode_eff_r),
    .halt_detect_out_r(halt_detect_out_r), .bandgap_on_r(bandgap_on_r),
    .unlocked_r(unlocked_r), .test_mode_r(test_mode_r),
    .test_dec_r(test_dec_r));

  always #2 core_clk = ~core_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Requests are raised at a falling edge and dropped one cycle later; the
  // extra idle cycle keeps two strobes from landing in one time step.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    chk(reg_rdata_r, exp);
    reg_rd = 1'b0;
    @(negedge core_clk);
    chk(reg_rdata_r, 8'h00);
  endtask

  task automatic settle;
    @(negedge core_clk);
    @(negedge core_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({2'h0, analog_r}, 8'h18);
    chk({7'h00, unlocked_r}, 8'h00);
    chk({4'h0, test_mode_r}, 8'h00);
    rchk(`TCL_ADDR_KEY1, 8'h00);
    rchk(`TCL_ADDR_KEY2, 8'h00);
    rchk(`TCL_ADDR_PUMP, 8'h00);
    rchk(`TCL_ADDR_HALT, 8'h00);
    rchk(`TCL_ADDR_BGAP, 8'h00);
    rchk(`TCL_ADDR_TEST, 8'h00);
    wr(`TCL_ADDR_PUMP, 8'hFF);
    wr(`TCL_ADDR_TEST, 8'h07);
    chk({2'h0, analog_r}, 8'h18);
    chk({4'h0, test_mode_r}, 8'h00);
    $display("test reset and lock done");
  endtask

  task automatic t_unlock;
    wr(`TCL_ADDR_KEY1, 8'hA5);
    chk({7'h00, unlocked_r}, 8'h00);
    wr(`TCL_ADDR_KEY2, 8'h3C);
    chk({7'h00, unlocked_r}, 8'h01);
    rchk(`TCL_ADDR_KEY1, 8'hA5);
    rchk(`TCL_ADDR_PUMP, 8'h01);
    rchk(`TCL_ADDR_HALT, 8'h10);
    $display("test unlock done");
  endtask

  task automatic t_pump;
    wr(`TCL_ADDR_PUMP, 8'h01);
    chk({7'h00, pump_mode_eff_r}, 8'h00);
    pump_mode_hw = 1'b1;
    settle();
    chk({7'h00, pump_mode_eff_r}, 8'h01);
    wr(`TCL_ADDR_PUMP, 8'hF0);
    chk({7'h00, pump_mode_eff_r}, 8'h00);
    rchk(`TCL_ADDR_PUMP, 8'hF0);
    pump_mode_hw = 1'b0;
    wr(`TCL_ADDR_PUMP, 8'h1F);
    chk({7'h00, pump_mode_eff_r}, 8'h01);
    $display("test pump mode done");
  endtask

  task automatic t_halt;
    wr(`TCL_ADDR_HALT, 8'h01);
    chk({7'h00, halt_detect_out_r}, 8'h01);
    chk({2'h0, analog_r}, 8'h32);
    wr(`TCL_ADDR_HALT, 8'h12);
    chk({7'h00, halt_detect_out_r}, 8'h00);
    chk({2'h0, analog_r}, 8'h3C);
    halt_detect_raw = 1'b1;
    settle();
    chk({7'h00, halt_detect_out_r}, 8'h01);
    halt_detect_raw = 1'b0;
    wr(`TCL_ADDR_HALT, 8'hEC);
    chk({2'h0, analog_r}, 8'h30);
    rchk(`TCL_ADDR_HALT, 8'hEC);
    $display("test halt detector done");
  endtask

  task automatic t_bgap;
    wr(`TCL_ADDR_BGAP, 8'h01);
    chk({7'h00, bandgap_on_r}, 8'h00);
    test_mode_active = 1'b1;
    settle();
    chk({7'h00, bandgap_on_r}, 8'h01);
    wr(`TCL_ADDR_BGAP, 8'hFE);
    chk({7'h00, bandgap_on_r}, 8'h00);
    rchk(`TCL_ADDR_BGAP, 8'hFE);
    $display("test bandgap done");
  endtask

  task automatic t_modes;
    logic [7:0] e;
    for (int m = 0; m < 8; m++) begin
      e = (m == 0) ? 8'h00 : (8'h40 >> (m - 1));
      wr(`TCL_ADDR_TEST, 8'h90 | 8'(m));
      chk({4'h0, test_mode_r}, 8'(m));
      chk({1'b0, test_dec_r}, e);
    end
    rchk(`TCL_ADDR_TEST, 8'h97);
    $display("test mode decode done");
  endtask

  task automatic t_relock;
    wr(`TCL_ADDR_KEY2, 8'h3D);
    chk({7'h00, unlocked_r}, 8'h00);
    rchk(`TCL_ADDR_TEST, 8'h00);
    wr(`TCL_ADDR_TEST, 8'h00);
    wr(`TCL_ADDR_KEY2, 8'h3C);
    rchk(`TCL_ADDR_TEST, 8'h97);
    $display("test relock done");
  endtask

  // A reset in mid-run must clear the keys and relock the test registers.
  task automatic t_rearm;
    sys_rst = 1'b1;
    @(negedge core_clk);
    chk({7'h00, unlocked_r}, 8'h00);
    chk({2'h0, analog_r}, 8'h18);
    sys_rst = 1'b0;
    @(negedge core_clk);
    rchk(`TCL_ADDR_KEY2, 8'h00);
    rchk(`TCL_ADDR_TEST, 8'h00);
    chk({4'h0, test_mode_r}, 8'h00);
    chk({1'b0, test_dec_r}, 8'h00);
    $display("test mid-run reset done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_unlock();
    t_pump();
    t_halt();
    t_bgap();
    t_modes();
    t_relock();
    t_rearm();
    test_done();
  end

  // The whole run needs about 100 cycles; 1000 cycles leave a wide margin.
  initial begin
    #4000;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire

// file: tcl_bank.sv
// Test and analog control register bank with two-word unlock key.
// Assumes a synchronous single-cycle register port from the serial
// control decoder, and a raw clock halt detector output from analog.
// How it works
// - The register pump mode choice applies only while its enable bit is 1.
// - Pump mode select is 0 for normal, 1 for constant current; resets to 1.
// - Halt detector power bit 0 powers down, 1 powers up; resets to 1.
// - Halt detector current bit 1 runs at four times current; resets to 0.
// - Halt detector disable bit 1 disables it and forces its output to 1.
// - Bandgap power bit keeps the bandgap down at 0 and up at 1 in test.
// - Test registers unlock only while both key words hold their values.
// - While locked, test register writes are ignored and reads give 0.
// - The 4-bit test field decodes normal, scan, IDDQ and five pin test modes.
`include "tcl_cfg.svh"
`default_nettype none
module tcl_bank #(
  parameter logic [7:0] KEY_ONE = `TCL_KEY1_DEF,
  parameter logic [7:0] KEY_TWO = `TCL_KEY2_DEF,
  parameter logic [5:0] TEST_SET = `TCL_SET_DEF,
  parameter int ADDR_W = `TCL_ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // Analog side
  input wire logic halt_detect_raw,
  input wire logic pump_mode_hw,
  input wire logic test_mode_active,
  output tcl_pkg::tcl_analog_t analog_r,
  output logic pump_mode_eff_r,
  output logic halt_detect_out_r,
  output logic bandgap_on_r,
  output logic unlocked_r,
  output tcl_pkg::tcl_test_mode_t test_mode_r,
  output tcl_pkg::tcl_test_dec_t test_dec_r
);

  // TEST_SET bit order: pump, halt, bandgap, unused, unused, test select.
  // The decoder compares against fixed offsets, so no other width works.
  if (ADDR_W != `TCL_ADDR_W) begin : g_addr_w_check
    $error("tcl_bank supports a 7-bit register address only");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] pump_r, halt_r, bgap_r, key1_r, key2_r, test_r;
  logic [7:0] pump_nxt, halt_nxt, bgap_nxt, key1_nxt, key2_nxt, test_nxt;
  logic unlocked;
  logic [7:0] rdata_nxt;

  function automatic logic gated(input logic [ADDR_W-1:0] a,
    input logic open_now);
    logic hit;
    hit = 1'b0;
    unique case (a)
      `TCL_ADDR_PUMP: hit = TEST_SET[`TCL_SET_PUMP];
      `TCL_ADDR_HALT: hit = TEST_SET[`TCL_SET_HALT];
      `TCL_ADDR_BGAP: hit = TEST_SET[`TCL_SET_BGAP];
      `TCL_ADDR_TEST: hit = TEST_SET[`TCL_SET_TEST];
      default: hit = 1'b0;
    endcase
    return hit && !open_now;
  endfunction

  // Both key words are compared in one place so the live lock and its
  // registered copy can never disagree.
  function automatic logic keys_match(input logic [7:0] k1,
    input logic [7:0] k2);
    return (k1 == KEY_ONE) && (k2 == KEY_TWO);
  endfunction

  // One field map serves the reset value and the live decode, so the
  // two cannot drift apart when a bit moves.
  function automatic tcl_pkg::tcl_analog_t split_fields(
    input logic [7:0] pump,
    input logic [7:0] halt,
    input logic [7:0] bgap
  );
    tcl_pkg::tcl_analog_t f;
    f.pump_mode_reg_enable = pump[`TCL_BIT_PUMP_EN];
    f.pump_mode_select = pump[`TCL_BIT_PUMP_SEL];
    f.halt_detector_power = halt[`TCL_BIT_HALT_PWR];
    f.halt_detector_quad_current = halt[`TCL_BIT_HALT_X4];
    f.halt_detector_disable = halt[`TCL_BIT_HALT_DIS];
    f.bandgap_power = bgap[`TCL_BIT_BGAP];
    return f;
  endfunction

  // Lock follows the stored key words with no extra latency.
  assign unlocked = keys_match(key1_r, key2_r);

  always_comb begin
    pump_nxt = pump_r;
    halt_nxt = halt_r;
    bgap_nxt = bgap_r;
    key1_nxt = key1_r;
    key2_nxt = key2_r;
    test_nxt = test_r;
    rdata_nxt = 8'h00;
    // Whole bytes are stored so reserved bits read back as written.
    if (reg_wr && !gated(reg_addr, unlocked)) begin
      unique case (reg_addr)
        `TCL_ADDR_PUMP: pump_nxt = reg_wdata;
        `TCL_ADDR_HALT: halt_nxt = reg_wdata;
        `TCL_ADDR_BGAP: bgap_nxt = reg_wdata;
        `TCL_ADDR_KEY1: key1_nxt = reg_wdata;
        `TCL_ADDR_KEY2: key2_nxt = reg_wdata;
        `TCL_ADDR_TEST: test_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd && !gated(reg_addr, unlocked)) begin
      unique case (reg_addr)
        `TCL_ADDR_PUMP: rdata_nxt = pump_r;
        `TCL_ADDR_HALT: rdata_nxt = halt_r;
        `TCL_ADDR_BGAP: rdata_nxt = bgap_r;
        `TCL_ADDR_KEY1: rdata_nxt = key1_r;
        `TCL_ADDR_KEY2: rdata_nxt = key2_r;
        `TCL_ADDR_TEST: rdata_nxt = test_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_r <= `TCL_RST_PUMP;
      halt_r <= `TCL_RST_HALT;
      bgap_r <= `TCL_RST_BGAP;
      key1_r <= `TCL_RST_KEY;
      key2_r <= `TCL_RST_KEY;
      test_r <= `TCL_RST_TEST;
      reg_rdata_r <= 8'h00;
    end else begin
      pump_r <= pump_nxt;
      halt_r <= halt_nxt;
      bgap_r <= bgap_nxt;
      key1_r <= key1_nxt;
      key2_r <= key2_nxt;
      test_r <= test_nxt;
      reg_rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  tcl_pkg::tcl_analog_t analog_nxt;
  tcl_pkg::tcl_test_mode_t mode_nxt;
  tcl_pkg::tcl_test_dec_t dec_nxt;
  logic pump_eff_nxt, halt_out_nxt, bgap_on_nxt;

  always_comb begin
    analog_nxt = split_fields(pump_nxt, halt_nxt, bgap_nxt);
    // Register select overrides the hardware choice only when enabled.
    pump_eff_nxt = pump_nxt[`TCL_BIT_PUMP_EN] ?
      pump_nxt[`TCL_BIT_PUMP_SEL] : pump_mode_hw;
    // A disabled detector must look like a running clock downstream.
    halt_out_nxt = halt_nxt[`TCL_BIT_HALT_DIS] | halt_detect_raw;
    bgap_on_nxt = test_mode_active & bgap_nxt[`TCL_BIT_BGAP];
    mode_nxt = tcl_pkg::tcl_test_mode_t'(test_nxt[`TCL_TEST_MSB:0]);
    dec_nxt.scan = (mode_nxt == tcl_pkg::TCL_TM_SCAN);
    dec_nxt.iddq = (mode_nxt == tcl_pkg::TCL_TM_IDDQ);
    dec_nxt.out_high = (mode_nxt == tcl_pkg::TCL_TM_OUT_HIGH);
    dec_nxt.out_low = (mode_nxt == tcl_pkg::TCL_TM_OUT_LOW);
    dec_nxt.in_low = (mode_nxt == tcl_pkg::TCL_TM_IN_LOW);
    dec_nxt.in_high = (mode_nxt == tcl_pkg::TCL_TM_IN_HIGH);
    dec_nxt.high_z = (mode_nxt == tcl_pkg::TCL_TM_HIGH_Z);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_r <= split_fields(`TCL_RST_PUMP, `TCL_RST_HALT, `TCL_RST_BGAP);
      pump_mode_eff_r <= 1'b0;
      halt_detect_out_r <= 1'b0;
      bandgap_on_r <= 1'b0;
      unlocked_r <= 1'b0;
      test_mode_r <= tcl_pkg::TCL_TM_NORMAL;
      test_dec_r <= '0;
    end else begin
      analog_r <= analog_nxt;
      pump_mode_eff_r <= pump_eff_nxt;
      halt_detect_out_r <= halt_out_nxt;
      bandgap_on_r <= bgap_on_nxt;
      unlocked_r <= keys_match(key1_nxt, key2_nxt);
      test_mode_r <= mode_nxt;
      test_dec_r <= dec_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_pump_sel;
    @(posedge core_clk) disable iff (sys_rst)
      pump_r[`TCL_BIT_PUMP_EN] |->
        pump_mode_eff_r == pump_r[`TCL_BIT_PUMP_SEL];
  endproperty
  a_pump_sel: assert property (p_pump_sel) else $error("pump sel");

  property p_pump_hw;
    @(posedge core_clk) disable iff (sys_rst)
      (!pump_nxt[`TCL_BIT_PUMP_EN]) |=>
        pump_mode_eff_r == $past(pump_mode_hw);
  endproperty
  a_pump_hw: assert property (p_pump_hw) else $error("pump hw");

  property p_halt_pwr;
    @(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> analog_r.halt_detector_power == halt_r[`TCL_BIT_HALT_PWR];
  endproperty
  a_halt_pwr: assert property (p_halt_pwr) else $error("halt pwr");

  property p_halt_x4;
    @(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> analog_r.halt_detector_quad_current ==
        halt_r[`TCL_BIT_HALT_X4];
  endproperty
  a_halt_x4: assert property (p_halt_x4) else $error("halt x4");

  property p_halt_dis;
    @(posedge core_clk) disable iff (sys_rst)
      halt_nxt[`TCL_BIT_HALT_DIS] |=> halt_detect_out_r;
  endproperty
  a_halt_dis: assert property (p_halt_dis) else $error("halt dis");

  property p_bgap;
    @(posedge core_clk) disable iff (sys_rst)
      !test_mode_active |=> !bandgap_on_r;
  endproperty
  a_bgap: assert property (p_bgap) else $error("bandgap on");

  property p_key_bad;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `TCL_ADDR_KEY2 && reg_wdata != KEY_TWO)
        |=> !unlocked_r;
  endproperty
  a_key_bad: assert property (p_key_bad) else $error("bad key");

  property p_lock_wr;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && !unlocked && reg_addr == `TCL_ADDR_TEST &&
        TEST_SET[`TCL_SET_TEST])
        |=> $stable(test_r);
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("locked write");

  property p_lock_rd;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_rd && !unlocked && reg_addr == `TCL_ADDR_PUMP &&
        TEST_SET[`TCL_SET_PUMP])
        |=> reg_rdata_r == 8'h00;
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("locked read");

  property p_mode;
    @(posedge core_clk) disable iff (sys_rst)
      test_dec_r.high_z |-> test_mode_r == tcl_pkg::TCL_TM_HIGH_Z;
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode");

  property p_open_wr;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && unlocked && reg_addr == `TCL_ADDR_TEST)
        |=> test_r == $past(reg_wdata);
  endproperty
  a_open_wr: assert property (p_open_wr) else $error("open write");

  property p_rsvd_kept;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && unlocked && reg_addr == `TCL_ADDR_HALT)
        |=> halt_r == $past(reg_wdata);
  endproperty
  a_rsvd_kept: assert property (p_rsvd_kept) else $error("rsvd");

  property p_dec_onehot;
    @(posedge core_clk) disable iff (sys_rst)
      $onehot0(test_dec_r);
  endproperty
  a_dec_onehot: assert property (p_dec_onehot) else $error("dec");

  property p_bgap_on;
    @(posedge core_clk) disable iff (sys_rst)
      (test_mode_active && bgap_nxt[`TCL_BIT_BGAP]) |=> bandgap_on_r;
  endproperty
  a_bgap_on: assert property (p_bgap_on) else $error("bandgap off");

  property p_halt_live;
    @(posedge core_clk) disable iff (sys_rst)
      !halt_nxt[`TCL_BIT_HALT_DIS] |=>
        halt_detect_out_r == $past(halt_detect_raw);
  endproperty
  a_halt_live: assert property (p_halt_live) else $error("halt live");

  property p_key_rd;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == `TCL_ADDR_KEY1) |=>
        reg_rdata_r == $past(key1_r);
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key read");

  c_unlock: cover property (@(posedge core_clk) disable iff (sys_rst)
    $rose(unlocked_r));
  c_pump: cover property (@(posedge core_clk) disable iff (sys_rst)
    analog_r.pump_mode_reg_enable && !pump_mode_eff_r);
  c_hiz: cover property (@(posedge core_clk) disable iff (sys_rst)
    test_dec_r.high_z);
  c_relock: cover property (@(posedge core_clk) disable iff (sys_rst)
    $fell(unlocked_r));
endmodule
`default_nettype wire

// file: tcl_cfg.svh
// Constants for the test control register bank: offsets, field positions,
// reset values and default unlock keys.
// Assumes an 8-bit register port with 7-bit addresses.
`ifndef TCL_CFG_SVH
`define TCL_CFG_SVH

`define TCL_ADDR_W 7
`define TCL_ADDR_PUMP 7'h2A
`define TCL_ADDR_HALT 7'h2B
`define TCL_ADDR_BGAP 7'h2C
`define TCL_ADDR_KEY1 7'h3F
`define TCL_ADDR_KEY2 7'h40
`define TCL_ADDR_TEST 7'h41

`define TCL_RST_PUMP 8'h01
`define TCL_RST_HALT 8'h10
`define TCL_RST_BGAP 8'h00
`define TCL_RST_KEY 8'h00
`define TCL_RST_TEST 8'h00

`define TCL_BIT_PUMP_EN 4
`define TCL_BIT_PUMP_SEL 0
`define TCL_BIT_HALT_PWR 4
`define TCL_BIT_HALT_X4 1
`define TCL_BIT_HALT_DIS 0
`define TCL_BIT_BGAP 0
`define TCL_TEST_MSB 3

// Position of each register in the lock set parameter.
`define TCL_SET_PUMP 0
`define TCL_SET_HALT 1
`define TCL_SET_BGAP 2
`define TCL_SET_TEST 5
`define TCL_SET_DEF 6'h3F

// Default key values are arbitrary.
`define TCL_KEY1_DEF 8'h5A
`define TCL_KEY2_DEF 8'hC3

`endif

// file: tcl_pkg.sv
// Types shared by the test control register bank.
// Uses no constants from tcl_cfg.svh; all enum values are written here.
`default_nettype none
package tcl_pkg;
  typedef enum logic [3:0] {
    TCL_TM_NORMAL = 4'h0,
    TCL_TM_SCAN = 4'h1,
    TCL_TM_IDDQ = 4'h2,
    TCL_TM_OUT_HIGH = 4'h3,
    TCL_TM_OUT_LOW = 4'h4,
    TCL_TM_IN_LOW = 4'h5,
    TCL_TM_IN_HIGH = 4'h6,
    TCL_TM_HIGH_Z = 4'h7
  } tcl_test_mode_t;

  typedef struct packed {
    logic pump_mode_reg_enable;
    logic pump_mode_select;
    logic halt_detector_power;
    logic halt_detector_quad_current;
    logic halt_detector_disable;
    logic bandgap_power;
  } tcl_analog_t;

  typedef struct packed {
    logic scan;
    logic iddq;
    logic out_high;
    logic out_low;
    logic in_low;
    logic in_high;
    logic high_z;
  } tcl_test_dec_t;
endpackage
`default_nettype wire
